// ---- brk_pkg.sv ----
// Package of register offsets, field positions, reset values and vectors for the breakpoint unit.
package brk_pkg;
	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_STATUS_CONTROL = 8'h00;
	localparam logic [7:0] OFF_ADDR_HIGH = 8'h04;
	localparam logic [7:0] OFF_ADDR_LOW = 8'h08;
	localparam logic [7:0] OFF_WAKE_STATUS = 8'h0c;
	localparam logic [7:0] OFF_FLAG_CONTROL = 8'h10;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BIT_MATCH_ENABLE = 7;
	localparam int BIT_ACTIVE = 6;
	localparam int BIT_WAKE = 1;
	localparam int BIT_FLAG_CLEAR = 7;
	localparam int BIT_EV_MATCH = 0;
	localparam int BIT_EV_SOFT = 1;
	localparam int BIT_EV_EXIT = 2;
	// ----------------------------------------
	// Reset values and vectors
	// ----------------------------------------
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [2:0] RST_EVENTS = 3'h0;
	localparam logic [15:0] VEC_USER = 16'hfffc;
	localparam logic [15:0] VEC_MONITOR = 16'hfefc;
endpackage : brk_pkg

// ---- brk_match.sv ----
// Address comparator that registers one match pulse per fetch.
`timescale 1ns/1ps
module brk_match
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Compare inputs
	input wire logic [15:0] addr,
	input wire logic addr_valid,
	input wire logic [15:0] target,
	input wire logic enable,
	// Result
	output logic hit
);
	logic hit_reg;
	logic hit_next;
	assign hit_next = enable && addr_valid && (addr == target);
	assign hit = hit_reg;
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			hit_reg <= 1'b0;
		else
			hit_reg <= hit_next;
	end
endmodule : brk_match

// ---- address_breakpoint_unit.sv ----
// Hardware breakpoint unit with APB registers, break request, freeze outputs and interrupt.
// Contract
// - New break address plus cleared active flag re-arms the unit for new breaks.
// - Clearing active flag with unchanged address gives no further break at that address.
// - Flag clears in other modules during break allowed only when clear-enable is 1.
// - Timer stops counting and ignores captures during break.
// - Watchdog held disabled during break when high test voltage is on reset pin.
// - Match enable at control bit 7 gates 16-bit matches; write 0 or reset clears.
// - Active flag set by hardware on enabled match; reads 1 on match.
// - Writing 1 to active flag triggers a break regardless of address.
// - Software clears active flag with 0 before exit; reset clears it.
// - High and low address byte registers, both cleared by reset.
// - Wake flag reads 1 when wait exited by break; readable in break routine.
// - Wake status register serves only emulation mode.
// - Unit stays enabled in wait and stop; no break fires there. The code still fires a pending soft trigger there.
// - Break forces software interrupt fetch with user or monitor break vector.
// - Opcode match suppresses that instruction; operand match lets it finish; soft before next.
// - Only program-counter addresses compare; return from interrupt ends the break.
`timescale 1ns/1ps
module address_breakpoint_unit
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// CPU side
	input wire logic [15:0] CPU_ADDR,
	input wire logic CPU_PC_FETCH,
	input wire logic CPU_OPCODE_FETCH,
	input wire logic CPU_INSTR_BOUNDARY,
	input wire logic CPU_RETURN_FROM_INTERRUPT,
	input wire logic CPU_IN_WAIT,
	input wire logic CPU_IN_STOP,
	input wire logic MONITOR_MODE,
	input wire logic EMULATION_MODE,
	input wire logic HIGH_TEST_VOLTAGE_RST,
	input wire logic STATUS_CLEAR_REQ,
	// Outputs to system integration, timer and watchdog
	output logic BREAKPOINT_REQUEST,
	output logic BREAK_SUPPRESS_OPCODE,
	output logic [15:0] BREAK_VECTOR,
	output logic BREAK_IN_PROGRESS,
	output logic STATUS_CLEAR_ALLOW,
	output logic TIMER_FREEZE,
	output logic CAPTURE_INHIBIT,
	output logic WATCHDOG_DISABLE,
	output logic IRQ
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic match_break_enable_reg;
	logic break_active_flag_reg;
	logic [7:0] break_addr_high_reg;
	logic [7:0] break_addr_low_reg;
	logic wait_exit_by_break_reg;
	logic flag_clear_in_break_enable_reg;
	logic [2:0] irq_status_reg;
	logic [2:0] irq_mask_reg;
	logic armed_reg;
	logic soft_pending_reg;
	logic in_break_reg;
	logic [31:0] prdata_reg;
	logic req_reg;
	logic suppress_reg;
	logic [15:0] vector_reg;
	logic freeze_reg;
	logic wdog_reg;
	logic allow_reg;
	logic irq_reg;
	logic pslverr_reg;

	// Decodes one register word from the bus address; every register select uses it.
	function automatic logic reg_select(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction : reg_select

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire access = PSEL && PENABLE;
	wire wr = access && PWRITE;
	wire rd = access && !PWRITE;
	wire sel_ctl = reg_select(PADDR, brk_pkg::OFF_STATUS_CONTROL);
	wire sel_hi = reg_select(PADDR, brk_pkg::OFF_ADDR_HIGH);
	wire sel_lo = reg_select(PADDR, brk_pkg::OFF_ADDR_LOW);
	wire sel_wake = reg_select(PADDR, brk_pkg::OFF_WAKE_STATUS);
	wire sel_fc = reg_select(PADDR, brk_pkg::OFF_FLAG_CONTROL);
	wire sel_is = reg_select(PADDR, brk_pkg::OFF_IRQ_STATUS);
	wire sel_im = reg_select(PADDR, brk_pkg::OFF_IRQ_MASK);
	wire mapped = sel_ctl || sel_hi || sel_lo || sel_wake || sel_fc || sel_is || sel_im;
	wire wr_ctl = wr && sel_ctl;
	wire wr_addr = wr && (sel_hi || sel_lo);
	wire soft_write = wr_ctl && PWDATA[brk_pkg::BIT_ACTIVE];
	wire [15:0] break_addr = {break_addr_high_reg, break_addr_low_reg};
	// ----------------------------------------
	// Break detection
	// ----------------------------------------
	logic hit;
	// Low-power modes keep the enable but the fetch strobe is masked, so no match break fires there; a pending soft trigger still fires.
	wire compare_valid = CPU_PC_FETCH && !CPU_IN_WAIT && !CPU_IN_STOP;
	brk_match u_match
	(
		.clk(CLK),
		.reset(RESET),
		.addr(CPU_ADDR),
		.addr_valid(compare_valid),
		.target(break_addr),
		.enable(match_break_enable_reg && armed_reg && !in_break_reg),
		.hit(hit)
	);
	logic hit_opcode_reg;
	// Soft trigger waits for the next instruction boundary so the current instruction completes.
	wire soft_fire = soft_pending_reg && CPU_INSTR_BOUNDARY && !in_break_reg;
	wire break_event = hit || soft_fire;
	wire return_event = CPU_RETURN_FROM_INTERRUPT && in_break_reg;
	wire [2:0] events = {return_event, soft_fire, hit};
	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	wire [7:0] ctl_rd = {match_break_enable_reg, break_active_flag_reg, 6'h00};
	wire [7:0] wake_rd = EMULATION_MODE ? {6'h00, wait_exit_by_break_reg, 1'b0} : 8'h00;
	wire [7:0] rd_byte = sel_ctl ? ctl_rd :
		sel_hi ? break_addr_high_reg :
		sel_lo ? break_addr_low_reg :
		sel_wake ? wake_rd :
		sel_fc ? {flag_clear_in_break_enable_reg, 7'h00} :
		sel_is ? {5'h00, irq_status_reg} :
		sel_im ? {5'h00, irq_mask_reg} : 8'h00;
	wire [2:0] irq_status_next = events | ((rd && sel_is) ? 3'h0 : irq_status_reg);
	// ----------------------------------------
	// Control state
	// ----------------------------------------
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
			match_break_enable_reg <= 1'b0;
		else if (wr_ctl)
			match_break_enable_reg <= PWDATA[brk_pkg::BIT_MATCH_ENABLE];
	end

	// A hardware match wins over a software write in the same cycle, so no match is lost.
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
			break_active_flag_reg <= 1'b0;
		else if (hit)
			break_active_flag_reg <= 1'b1;
		else if (wr_ctl)
			break_active_flag_reg <= PWDATA[brk_pkg::BIT_ACTIVE];
	end

	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
			break_addr_high_reg <= brk_pkg::RST_BYTE;
		else if (wr && sel_hi)
			break_addr_high_reg <= PWDATA[7:0];
	end

	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
			break_addr_low_reg <= brk_pkg::RST_BYTE;
		else if (wr && sel_lo)
			break_addr_low_reg <= PWDATA[7:0];
	end

	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
			flag_clear_in_break_enable_reg <= 1'b0;
		else if (wr && sel_fc)
			flag_clear_in_break_enable_reg <= PWDATA[brk_pkg::BIT_FLAG_CLEAR];
	end

	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
			irq_mask_reg <= brk_pkg::RST_EVENTS;
		else if (wr && sel_im)
			irq_mask_reg <= PWDATA[2:0];
	end

	// A match disarms; only a new address re-arms, so an unchanged address cannot rebreak.
	// Writing either address byte counts as a new address, even when the value is the same.
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
			armed_reg <= 1'b1;
		else if (hit)
			armed_reg <= 1'b0;
		else if (wr_addr)
			armed_reg <= 1'b1;
	end

	// A soft trigger is held until the core reaches an instruction boundary.
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
			soft_pending_reg <= 1'b0;
		else if (soft_write)
			soft_pending_reg <= 1'b1;
		else if (soft_fire)
			soft_pending_reg <= 1'b0;
	end

	// ----------------------------------------
	// Break state and outputs
	// ----------------------------------------
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
			in_break_reg <= 1'b0;
		else if (break_event)
			in_break_reg <= 1'b1;
		else if (return_event)
			in_break_reg <= 1'b0;
	end

	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
			wait_exit_by_break_reg <= 1'b0;
		else if (break_event)
			wait_exit_by_break_reg <= CPU_IN_WAIT;
	end

	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
			hit_opcode_reg <= 1'b0;
		else
			hit_opcode_reg <= CPU_OPCODE_FETCH;
	end

	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
			req_reg <= 1'b0;
		else
			req_reg <= break_event;
	end

	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
			suppress_reg <= 1'b0;
		else
			suppress_reg <= hit && hit_opcode_reg;
	end

	// The vector follows the mode every cycle, so it is settled when the request rises.
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
			vector_reg <= brk_pkg::VEC_USER;
		else
			vector_reg <= MONITOR_MODE ? brk_pkg::VEC_MONITOR : brk_pkg::VEC_USER;
	end

	// The freeze starts with the request and lasts one cycle past the return.
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
			freeze_reg <= 1'b0;
		else
			freeze_reg <= in_break_reg || break_event;
	end

	// The watchdog stays armed in a break unless the test voltage is present.
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
			wdog_reg <= 1'b0;
		else
			wdog_reg <= (in_break_reg || break_event) && HIGH_TEST_VOLTAGE_RST;
	end

	// A clear request passes outside a break, and inside one only when software allowed it.
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
			allow_reg <= 1'b0;
		else
			allow_reg <= STATUS_CLEAR_REQ && (!in_break_reg || flag_clear_in_break_enable_reg);
	end

	// ----------------------------------------
	// Bus answer and interrupt
	// ----------------------------------------
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			prdata_reg <= 32'h00000000;
			irq_status_reg <= brk_pkg::RST_EVENTS;
			irq_reg <= 1'b0;
		end
		else
		begin
			if (PSEL && !PENABLE && !PWRITE)
				prdata_reg <= {24'h000000, rd_byte};
			irq_status_reg <= irq_status_next;
			irq_reg <= |(irq_status_next & irq_mask_reg);
		end
	end

	// The error is decided in the setup cycle so that it stands from a flop through the access phase.
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
			pslverr_reg <= 1'b0;
		else
			pslverr_reg <= PSEL && !PENABLE && !mapped;
	end

	// ----------------------------------------
	// Output drive
	// ----------------------------------------
	assign PRDATA = prdata_reg;
	assign PREADY = 1'b1;
	assign PSLVERR = pslverr_reg;
	assign BREAKPOINT_REQUEST = req_reg;
	assign BREAK_SUPPRESS_OPCODE = suppress_reg;
	assign BREAK_VECTOR = vector_reg;
	assign BREAK_IN_PROGRESS = in_break_reg;
	assign STATUS_CLEAR_ALLOW = allow_reg;
	assign TIMER_FREEZE = freeze_reg;
	assign CAPTURE_INHIBIT = freeze_reg;
	assign WATCHDOG_DISABLE = wdog_reg;
	assign IRQ = irq_reg;
endmodule : address_breakpoint_unit

// ---- brk_cpu_model.sv ----
// Behavioural CPU core that fetches opcodes and returns from the break routine.
`timescale 1ns/1ps
module brk_cpu_model
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Control from the bench
	input wire logic run,
	input wire logic [15:0] start,
	input wire logic in_break,
	// Bus towards the unit
	output logic [15:0] addr,
	output logic pc_fetch,
	output logic opcode,
	output logic boundary,
	output logic return_from_interrupt
);
	logic [3:0] cnt_reg;
	// ----------------
	// Fetch sequencer
	// ----------------
	// Every fetch is an opcode fetch, so a breakpoint always sits on an opcode.
	assign pc_fetch = run && !in_break;
	assign opcode = pc_fetch;
	assign boundary = 1'b1;
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			addr <= 16'h0000;
			cnt_reg <= 4'h0;
			return_from_interrupt <= 1'b0;
		end
		else
		begin
			addr <= !run ? start : (pc_fetch ? addr + 16'h0001 : addr);
			cnt_reg <= in_break ? cnt_reg + 4'h1 : 4'h0;
			return_from_interrupt <= in_break && cnt_reg == 4'hf;
		end
	end
endmodule : brk_cpu_model

// ---- brk_asserts.sv ----
// Checker of break request, freeze and vector behaviour at the unit's ports.
`timescale 1ns/1ps
module brk_asserts
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// Observed ports
	input wire logic BREAKPOINT_REQUEST,
	input wire logic BREAK_IN_PROGRESS,
	input wire logic BREAK_SUPPRESS_OPCODE,
	input wire logic [15:0] BREAK_VECTOR,
	input wire logic MONITOR_MODE,
	input wire logic TIMER_FREEZE,
	input wire logic CAPTURE_INHIBIT,
	input wire logic WATCHDOG_DISABLE,
	input wire logic HIGH_TEST_VOLTAGE_RST,
	input wire logic CPU_IN_WAIT,
	input wire logic CPU_IN_STOP,
	input wire logic CPU_RETURN_FROM_INTERRUPT
);
	default clocking dc @(posedge CLK);
	endclocking
	default disable iff (RESET);
	req_pulse_a: assert property (
		BREAKPOINT_REQUEST |=> !BREAKPOINT_REQUEST) else $error("request wider than one cycle");
	no_nested_a: assert property (
		BREAKPOINT_REQUEST |-> BREAK_IN_PROGRESS && !$past(BREAK_IN_PROGRESS)) else $error("request inside break");
	timer_freeze_a: assert property (
		1'b1 |-> TIMER_FREEZE == (BREAK_IN_PROGRESS || $past(BREAK_IN_PROGRESS)) && CAPTURE_INHIBIT == TIMER_FREEZE)
		else $error("timer freeze wrong");
	watchdog_off_a: assert property (
		1'b1 |-> WATCHDOG_DISABLE == ((BREAK_IN_PROGRESS || $past(BREAK_IN_PROGRESS)) && $past(HIGH_TEST_VOLTAGE_RST)))
		else $error("watchdog disable wrong");
	vector_sel_a: assert property (
		BREAKPOINT_REQUEST |-> BREAK_VECTOR == ($past(MONITOR_MODE) ? brk_pkg::VEC_MONITOR : brk_pkg::VEC_USER))
		else $error("break vector wrong");
	low_power_a: assert property (
		(CPU_IN_WAIT || CPU_IN_STOP) [*3] |-> !BREAKPOINT_REQUEST) else $error("break in low power mode");
	rti_end_a: assert property (
		BREAK_IN_PROGRESS && CPU_RETURN_FROM_INTERRUPT |=> !BREAK_IN_PROGRESS) else $error("break not ended");
	suppress_pair_a: assert property (
		BREAK_SUPPRESS_OPCODE |-> BREAKPOINT_REQUEST) else $error("suppress without request");
	cover property (BREAKPOINT_REQUEST && MONITOR_MODE);
	cover property (BREAK_SUPPRESS_OPCODE);
	cover property (WATCHDOG_DISABLE);
endmodule : brk_asserts
bind address_breakpoint_unit brk_asserts chk (.CLK, .RESET, .BREAKPOINT_REQUEST, .BREAK_IN_PROGRESS,
	.BREAK_SUPPRESS_OPCODE, .BREAK_VECTOR, .MONITOR_MODE, .TIMER_FREEZE, .CAPTURE_INHIBIT, .WATCHDOG_DISABLE,
	.HIGH_TEST_VOLTAGE_RST, .CPU_IN_WAIT, .CPU_IN_STOP, .CPU_RETURN_FROM_INTERRUPT);

// ---- tb_top.sv ----
// Self-checking bench for the breakpoint unit.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
	logic CLK = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR, IRQ, run = 0, err;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0, PRDATA, q;
	logic [15:0] CPU_ADDR, BREAK_VECTOR, start = 16'h0120;
	logic CPU_PC_FETCH, CPU_OPCODE_FETCH, CPU_INSTR_BOUNDARY, CPU_RETURN_FROM_INTERRUPT;
	logic CPU_IN_WAIT = 0, CPU_IN_STOP = 0, MONITOR_MODE = 0, EMULATION_MODE = 0;
	logic HIGH_TEST_VOLTAGE_RST = 0, STATUS_CLEAR_REQ = 1;
	logic BREAKPOINT_REQUEST, BREAK_SUPPRESS_OPCODE, BREAK_IN_PROGRESS, STATUS_CLEAR_ALLOW;
	logic TIMER_FREEZE, CAPTURE_INHIBIT, WATCHDOG_DISABLE;
	int fails = 0, compares = 0;
	always #4 CLK = ~CLK;
	address_breakpoint_unit DUT (.CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
		.PSLVERR, .CPU_ADDR, .CPU_PC_FETCH, .CPU_OPCODE_FETCH, .CPU_INSTR_BOUNDARY, .CPU_RETURN_FROM_INTERRUPT,
		.CPU_IN_WAIT, .CPU_IN_STOP, .MONITOR_MODE, .EMULATION_MODE, .HIGH_TEST_VOLTAGE_RST, .STATUS_CLEAR_REQ,
		.BREAKPOINT_REQUEST, .BREAK_SUPPRESS_OPCODE, .BREAK_VECTOR, .BREAK_IN_PROGRESS, .STATUS_CLEAR_ALLOW,
		.TIMER_FREEZE, .CAPTURE_INHIBIT, .WATCHDOG_DISABLE, .IRQ);
	brk_cpu_model cpu (.clk(CLK), .reset(RESET), .run(run), .start(start), .in_break(BREAK_IN_PROGRESS),
		.addr(CPU_ADDR), .pc_fetch(CPU_PC_FETCH), .opcode(CPU_OPCODE_FETCH), .boundary(CPU_INSTR_BOUNDARY),
		.return_from_interrupt(CPU_RETURN_FROM_INTERRUPT));
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do @(posedge CLK); while (PREADY !== 1'b1);
		q = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : xfer
	// Runs the core from the start address and looks for one break request.
	task automatic expect_req(input logic e);
		logic seen;
		seen = 1'b0;
		@(posedge CLK);
		run <= 1'b1;
		for (int i = 0; i < 30 && !seen; i++)
		begin
			@(posedge CLK);
			seen = (BREAKPOINT_REQUEST === 1'b1);
		end
		run <= 1'b0;
		@(negedge CLK);
		`CHK(seen, e)
	endtask : expect_req
	task automatic wait_end();
		for (int n = 0; n < 40 && BREAK_IN_PROGRESS !== 1'b0; n++)
			@(posedge CLK);
		`CHK(BREAK_IN_PROGRESS, 1'b0)
	endtask : wait_end
	task automatic stop_test();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test
	initial
	begin
		#50us;
		fails++;
		stop_test();
	end
	initial
	begin
		repeat (20) @(posedge CLK);
		RESET <= 1'b0;
		for (int a = 0; a <= 16; a += 4)
		begin
			xfer(1'b0, 8'(a), 32'h0);
			`CHK(q, 32'h0)
		end
		xfer(1'b0, 8'h1c, 32'h0);
		`CHK({err, q}, {1'b1, 32'h0})
		$display("reset test done");
		xfer(1'b1, brk_pkg::OFF_ADDR_HIGH, 32'h01);
		xfer(1'b1, brk_pkg::OFF_ADDR_LOW, 32'h23);
		xfer(1'b1, brk_pkg::OFF_STATUS_CONTROL, 32'h80);
		expect_req(1'b1);
		`CHK({TIMER_FREEZE, CAPTURE_INHIBIT, STATUS_CLEAR_ALLOW, BREAK_VECTOR}, {3'b110, brk_pkg::VEC_USER})
		xfer(1'b0, brk_pkg::OFF_STATUS_CONTROL, 32'h0);
		`CHK(q, 32'hc0)
		xfer(1'b1, brk_pkg::OFF_STATUS_CONTROL, 32'h80);
		wait_end();
		xfer(1'b0, brk_pkg::OFF_IRQ_STATUS, 32'h0);
		`CHK(q, 32'h5)
		xfer(1'b0, brk_pkg::OFF_IRQ_STATUS, 32'h0);
		repeat (2) @(negedge CLK);
		`CHK({q, IRQ}, 33'h0)
		expect_req(1'b0);
		$display("match test done");
		xfer(1'b1, brk_pkg::OFF_ADDR_LOW, 32'h25);
		MONITOR_MODE <= 1'b1;
		expect_req(1'b1);
		`CHK(BREAK_VECTOR, brk_pkg::VEC_MONITOR)
		xfer(1'b1, brk_pkg::OFF_STATUS_CONTROL, 32'h0);
		wait_end();
		xfer(1'b1, brk_pkg::OFF_ADDR_LOW, 32'h27);
		expect_req(1'b0);
		xfer(1'b1, brk_pkg::OFF_STATUS_CONTROL, 32'h80);
		xfer(1'b1, brk_pkg::OFF_ADDR_LOW, 32'h29);
		CPU_IN_WAIT <= 1'b1;
		expect_req(1'b0);
		xfer(1'b1, brk_pkg::OFF_FLAG_CONTROL, 32'h80);
		CPU_IN_WAIT <= 1'b0;
		HIGH_TEST_VOLTAGE_RST <= 1'b1;
		expect_req(1'b1);
		`CHK({STATUS_CLEAR_ALLOW, WATCHDOG_DISABLE}, 2'b11)
		xfer(1'b1, brk_pkg::OFF_STATUS_CONTROL, 32'h0);
		wait_end();
		xfer(1'b1, brk_pkg::OFF_IRQ_MASK, 32'h7);
		xfer(1'b0, brk_pkg::OFF_IRQ_STATUS, 32'h0);
		repeat (2) @(negedge CLK);
		`CHK(IRQ, 1'b0)
		xfer(1'b1, brk_pkg::OFF_STATUS_CONTROL, 32'h40);
		expect_req(1'b1);
		`CHK(IRQ, 1'b1)
		xfer(1'b0, brk_pkg::OFF_IRQ_STATUS, 32'h0);
		`CHK(q, 32'h2)
		xfer(1'b1, brk_pkg::OFF_STATUS_CONTROL, 32'h0);
		wait_end();
		$display("mode test done");
		stop_test();
	end
endmodule : tb_top
